/* tb_top.sv */
// Testbench: drives commands and checks replies and pins.
`timescale 1ns/100ps
module tb_top;
    logic clk, arst_n, cmd_valid, tx_ready, event_in, tx_valid, resp_done, slow, clr;
    wlf_pkg::wlf_cmd_type cmd_code;
    wlf_pkg::wlf_rx_type rx;
    wlf_pkg::wlf_status_type resp_status;
    logic [14:0] din, dout;
    logic [3:0] baud_sel;
    logic [15:0] event_count, e;
    logic [7:0] tx_char, hn;
    logic [63:0] hv;
    int bad_count, cmp_count;
    int fl[4] = '{0, 10, 20, 40};
    // Short filter counts keep the run brief.
    wlf_core #(.FILT5_CYC(10), .FILT20_CYC(20), .FILT50_CYC(40)) dut (.clk(clk), .arst_n(arst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rx(rx), .tx_ready(tx_ready), .din(din),
        .event_in(event_in), .tx_valid(tx_valid), .tx_char(tx_char), .resp_done(resp_done),
        .resp_status(resp_status), .dout(dout), .baud_sel(baud_sel), .event_count(event_count));
    wlf_host_model host (.clk(clk), .arst_n(arst_n), .slow(slow), .clr(clr), .tx_valid(tx_valid),
        .tx_char(tx_char), .tx_ready(tx_ready), .n_ff(hn), .v_ff(hv));
    // Clock at 50 ns.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Compares one seen value with its expected value.
    task automatic chk(input logic [71:0] s, input logic [71:0] x);
        cmp_count++;
        if (s !== x) begin
            bad_count++;
            $display("BAD %0t saw %h want %h", $time, s, x);
        end
    endtask
    // Sends one command with its digits, waits for completion, checks status and reply.
    task automatic cmd(input wlf_pkg::wlf_cmd_type c, input string a, input logic [1:0] st,
                       input logic [7:0] n, input logic [63:0] v);
        int k;
        cmd_valid = 1'b1;
        cmd_code = c;
        clr = 1'b1;
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        clr = 1'b0;
        for (k = 0; k < a.len(); k++) begin
            rx = '{1'b1, 1'b0, a[k]};
            @(posedge clk) #1;
        end
        rx = '{1'b1, 1'b1, 8'h00};
        @(posedge clk) #1;
        rx = '0;
        // A bounded wait: a missing completion is counted and ends the run.
        for (k = 0; k < 400 && resp_done !== 1'b1; k++) @(posedge clk) #1;
        if (resp_done !== 1'b1) begin
            bad_count++;
            test_done();
        end
        chk(resp_status, st);
        chk({hn, hv}, {n, v});
        @(posedge clk) #1;
    endtask
    // Write enable, which must come straight before a protected command.
    task automatic we();
        cmd(wlf_pkg::WLF_WRITE_ENABLE_CMD, "", 2'h0, 8'h00, 64'h0);
    endtask
    // Raises the event input for w cycles, then leaves it low long enough to settle.
    task automatic pulse(input int w);
        event_in = 1'b1;
        repeat (w) @(posedge clk) #1;
        event_in = 1'b0;
        repeat (60) @(posedge clk) #1;
    endtask
    // Main sequence.
    initial begin
        bad_count = 0;
        cmp_count = 0;
        arst_n = 1'b0;
        {cmd_valid, event_in, slow, clr} = 4'h0;
        cmd_code = wlf_pkg::WLF_WRITE_ENABLE_CMD;
        rx = '0;
        din = 15'h5ACD;
        e = 16'h0000;
        repeat (4) @(posedge clk);
        #1 arst_n = 1'b1;
        chk({dout, baud_sel, event_count}, {15'h0000, 4'h7, 16'h0000});
        cmd(wlf_pkg::WLF_SETUP_READ_CMD, "", 2'h0, 8'h08, 64'h31070102);
        cmd(wlf_pkg::WLF_SETUP_WRITE_CMD, "31070101", 2'h2, 8'h00, 64'h0);
        cmd(wlf_pkg::WLF_SETUP_READ_CMD, "", 2'h0, 8'h08, 64'h31070102);
        cmd(wlf_pkg::WLF_PARALLEL_OUTPUT_CMD, "1234", 2'h0, 8'h00, 64'h0);
        chk(dout, 15'h1234);
        cmd(wlf_pkg::WLF_PARALLEL_OUTPUT_CMD, "12345", 2'h1, 8'h00, 64'h0);
        chk(dout, 15'h1234);
        cmd(wlf_pkg::WLF_OUTPUT_READBACK_CMD, "", 2'h0, 8'h04, 64'h9234);
        // Three words, with the host stalling every digit after the first.
        slow = 1'b1;
        we();
        cmd(wlf_pkg::WLF_SETUP_WRITE_CMD, "31070103", 2'h0, 8'h00, 64'h0);
        cmd(wlf_pkg::WLF_SETUP_READ_CMD, "", 2'h0, 8'h08, 64'h31070103);
        cmd(wlf_pkg::WLF_PARALLEL_OUTPUT_CMD, "123456", 2'h0, 8'h00, 64'h0);
        chk(dout, 15'h3456);
        cmd(wlf_pkg::WLF_OUTPUT_READBACK_CMD, "", 2'h0, 8'h06, 64'hFFB456);
        slow = 1'b0;
        // One word: upper lines are cut off, single-line commands keep full reach.
        we();
        cmd(wlf_pkg::WLF_SETUP_WRITE_CMD, "31070101", 2'h0, 8'h00, 64'h0);
        cmd(wlf_pkg::WLF_PARALLEL_INPUT_CMD, "", 2'h0, 8'h02, 64'hCD);
        cmd(wlf_pkg::WLF_PARALLEL_OUTPUT_CMD, "34", 2'h0, 8'h00, 64'h0);
        chk(dout, 15'h0034);
        cmd(wlf_pkg::WLF_SET_BIT_CMD, "0A", 2'h0, 8'h00, 64'h0);
        chk(dout, 15'h0434);
        cmd(wlf_pkg::WLF_CLEAR_BIT_CMD, "02", 2'h0, 8'h00, 64'h0);
        chk(dout, 15'h0430);
        // A non-hex digit and an index past the physical lines are both refused.
        cmd(wlf_pkg::WLF_PARALLEL_OUTPUT_CMD, "G4", 2'h1, 8'h00, 64'h0);
        chk(dout, 15'h0430);
        cmd(wlf_pkg::WLF_SET_BIT_CMD, "0F", 2'h1, 8'h00, 64'h0);
        chk(dout, 15'h0430);
        // Eight words: every bit above the physical lines reads back as one.
        we();
        cmd(wlf_pkg::WLF_SETUP_WRITE_CMD, "31070108", 2'h0, 8'h00, 64'h0);
        cmd(wlf_pkg::WLF_OUTPUT_READBACK_CMD, "", 2'h0, 8'h10, 64'hFFFFFFFFFFFF8430);
        // Every filter code: a long level is counted; with a filter on, a short burst is dropped.
        for (int f = 0; f < 4; f++) begin
            we();
            cmd(wlf_pkg::WLF_SETUP_WRITE_CMD, $sformatf("310701%0d2", f), 2'h0, 8'h00, 64'h0);
            if (f > 0) begin
                pulse(fl[f] / 2);
                chk(event_count, e);
            end
            pulse(fl[f] + 2);
            e = e + 16'h0001;
            chk(event_count, e);
        end
        cmd(wlf_pkg::WLF_INPUT_VALUE_READ_CMD, "", 2'h0, 8'h04, {48'h0, e});
        // Baud changes only through a protected remote reset.
        we();
        cmd(wlf_pkg::WLF_SETUP_WRITE_CMD, "31020102", 2'h0, 8'h00, 64'h0);
        chk(baud_sel, 4'h7);
        cmd(wlf_pkg::WLF_REMOTE_RESET_CMD, "", 2'h2, 8'h00, 64'h0);
        chk(baud_sel, 4'h7);
        we();
        cmd(wlf_pkg::WLF_REMOTE_RESET_CMD, "", 2'h0, 8'h00, 64'h0);
        chk(baud_sel, 4'h2);
        // A mid-run reset brings back the factory setup and baud.
        arst_n = 1'b0;
        @(posedge clk) #1;
        arst_n = 1'b1;
        chk({dout, baud_sel, event_count}, {15'h0000, 4'h7, 16'h0000});
        cmd(wlf_pkg::WLF_SETUP_READ_CMD, "", 2'h0, 8'h08, 64'h31070102);
        test_done();
    end
endmodule

/* wlf_core.sv */
// Setup byte 4 command block: word length, parallel data and event filter.
// Operation
// - Bits 5:4 choose none, 5, 20, 50 ms
// - No filter follows inputs to 20 kHz
// - Word length one to eight, zero illegal; the code accepts zero and clamps it to one, and 9 to 15 to eight
// - Each word is eight bits, two digits
// - Wrong output digit count gives syntax error
// - Reads answer exactly configured word count
// - Rightmost digit is least significant line
// - Output bits above physical lines are dropped
// - Readback reports bits above physical width as ones
// - Single-line commands ignore word length
// - Setup write needs write enable just before
// - Factory setup is 31070102
// - Setup read returns full setup value
// - New setup applies at once, baud at reset
`timescale 1ns/100ps
module wlf_core #(
    parameter int FILT5_CYC = wlf_pkg::FILT5_CYC,
    parameter int FILT20_CYC = wlf_pkg::FILT20_CYC,
    parameter int FILT50_CYC = wlf_pkg::FILT50_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire wlf_pkg::wlf_cmd_type cmd_code,
    input wire wlf_pkg::wlf_rx_type rx,
    input wire logic tx_ready,
    input wire logic [wlf_pkg::PHYS_LINES-1:0] din,
    input wire logic event_in,
    output logic tx_valid,
    output logic [7:0] tx_char,
    output logic resp_done,
    output wlf_pkg::wlf_status_type resp_status,
    output logic [wlf_pkg::PHYS_LINES-1:0] dout,
    output logic [wlf_pkg::BAUD_W-1:0] baud_sel,
    output logic [wlf_pkg::EVT_W-1:0] event_count
);

    wlf_pkg::wlf_core_type s; // Registered state.
    wlf_pkg::wlf_core_type n; // Next state.
    logic evt_stable; // Debounced event input.
    logic [7:0] hex_char; // ASCII form of the next reply digit.
    logic [3:0] rx_val; // Value of the arriving digit.
    logic rx_hex; // Arriving character is a hex digit.
    logic [3:0] wlen; // Word length clamped to its legal range.
    logic [4:0] want; // Digits a parallel value occupies.
    localparam int DATA_W_L = wlf_pkg::DATA_W; // Widest parallel value, declared before its first use.
    logic [DATA_W_L-1:0] ones_top; // Ones above the physical lines.

    // Debounce filter steered by the live filter field.
    wlf_filter #(
        .FILT5_CYC(FILT5_CYC),
        .FILT20_CYC(FILT20_CYC),
        .FILT50_CYC(FILT50_CYC)
    ) u_filter (
        .clk(clk),
        .arst_n(arst_n),
        .raw(event_in),
        .sel(s.setup[wlf_pkg::FILT_LSB +: wlf_pkg::FILT_W]),
        .stable(evt_stable)
    );

    // One codec serves the arriving and the departing digit.
    wlf_hex u_hex (
        .nibble(s.rdata[DATA_W_L-1 -: 4]),
        .char_in(rx.char),
        .char_out(hex_char),
        .value(rx_val),
        .is_hex(rx_hex)
    );

    // A zero or oversized length is the host's fault; clamping keeps the
    // digit arithmetic in range instead of producing a runaway reply.
    always_comb begin
        wlen = s.setup[wlf_pkg::WLEN_LSB +: wlf_pkg::WLEN_W];
        if (wlen < wlf_pkg::WLEN_MIN) begin
            wlen = wlf_pkg::WLEN_MIN;
        end else if (wlen > wlf_pkg::WLEN_MAX) begin
            wlen = wlf_pkg::WLEN_MAX;
        end
        want = 5'({1'b0, wlen} * wlf_pkg::DIGITS_PER_WORD);
        ones_top = ~DATA_W_L'({wlf_pkg::PHYS_LINES{1'b1}});
    end

    // Command sequencer: gather digits, act on the terminator, then stream
    // the reply most significant digit first.
    always_comb begin
        n = s;
        n.done = 1'b0;
        n.evt_prev = evt_stable;
        if (evt_stable && !s.evt_prev) begin
            n.evcnt = s.evcnt + 1'b1;
        end
        if (s.tx_valid && tx_ready) begin
            n.tx_valid = 1'b0;
        end
        case (s.state)
            wlf_pkg::WLF_IDLE: begin
                if (cmd_valid) begin
                    n.code = cmd_code;
                    n.ndig = '0;
                    n.argsh = '0;
                    n.bad = 1'b0;
                    n.state = wlf_pkg::WLF_ARGS;
                end
            end
            wlf_pkg::WLF_ARGS: begin
                if (rx.valid && !rx.last) begin
                    if (!rx_hex) begin
                        n.bad = 1'b1;
                    end
                    // Digits shift in from the right, so the last one typed
                    // is the least significant.
                    n.argsh = {s.argsh[DATA_W_L-5:0], rx_val};
                    if (s.ndig != wlf_pkg::MAX_DIGITS) begin
                        n.ndig = s.ndig + 1'b1;
                    end
                end else if (rx.valid) begin
                    n.status = wlf_pkg::WLF_ST_OK;
                    n.state = wlf_pkg::WLF_IDLE;
                    n.done = 1'b1;
                    // The enable lasts for exactly one following command.
                    n.we_armed = 1'b0;
                    case (s.code)
                        wlf_pkg::WLF_WRITE_ENABLE_CMD: begin
                            n.we_armed = 1'b1;
                        end
                        wlf_pkg::WLF_SETUP_WRITE_CMD: begin
                            if (!s.we_armed) begin
                                n.status = wlf_pkg::WLF_ST_PROTECT;
                            end else if (s.bad || s.ndig != wlf_pkg::SETUP_DIGITS) begin
                                n.status = wlf_pkg::WLF_ST_SYNTAX;
                            end else begin
                                n.setup = s.argsh[31:0];
                            end
                        end
                        wlf_pkg::WLF_REMOTE_RESET_CMD: begin
                            if (!s.we_armed) begin
                                n.status = wlf_pkg::WLF_ST_PROTECT;
                            end else begin
                                n.baud = s.setup[wlf_pkg::BAUD_LSB +: wlf_pkg::BAUD_W];
                            end
                        end
                        wlf_pkg::WLF_PARALLEL_OUTPUT_CMD: begin
                            if (s.bad || s.ndig != want) begin
                                n.status = wlf_pkg::WLF_ST_SYNTAX;
                            end else begin
                                n.dout = s.argsh[wlf_pkg::PHYS_LINES-1:0];
                            end
                        end
                        wlf_pkg::WLF_SET_BIT_CMD, wlf_pkg::WLF_CLEAR_BIT_CMD: begin
                            // Index addressing never looks at the word length.
                            if (s.bad || s.ndig != wlf_pkg::INDEX_DIGITS ||
                                    s.argsh[7:0] >= 8'(wlf_pkg::PHYS_LINES)) begin
                                n.status = wlf_pkg::WLF_ST_SYNTAX;
                            end else begin
                                n.dout[s.argsh[3:0]] = (s.code == wlf_pkg::WLF_SET_BIT_CMD);
                            end
                        end
                        wlf_pkg::WLF_SETUP_READ_CMD: begin
                            // The full 32-bit value leaves as eight digits.
                            n.rdata = {s.setup, 32'h00000000};
                            n.ridx = wlf_pkg::SETUP_DIGITS;
                            n.done = 1'b0;
                            n.state = wlf_pkg::WLF_RESP;
                        end
                        wlf_pkg::WLF_PARALLEL_INPUT_CMD, wlf_pkg::WLF_OUTPUT_READBACK_CMD,
                                wlf_pkg::WLF_INPUT_VALUE_READ_CMD: begin
                            if (s.code == wlf_pkg::WLF_PARALLEL_INPUT_CMD) begin
                                n.rdata = ones_top | DATA_W_L'(din);
                            end else if (s.code == wlf_pkg::WLF_OUTPUT_READBACK_CMD) begin
                                n.rdata = ones_top | DATA_W_L'(s.dout);
                            end else begin
                                n.rdata = DATA_W_L'(s.evcnt);
                            end
                            // Left-align so the first digit sent is the top of
                            // the configured width; higher bits fall away.
                            n.rdata = n.rdata << (7'(wlf_pkg::DATA_W) - 7'({want, 2'b00}));
                            n.ridx = want;
                            n.done = 1'b0;
                            n.state = wlf_pkg::WLF_RESP;
                        end
                        default: begin
                            n.status = wlf_pkg::WLF_ST_SYNTAX;
                        end
                    endcase
                end
            end
            wlf_pkg::WLF_RESP: begin
                if (!s.tx_valid || tx_ready) begin
                    if (s.ridx != 5'h00) begin
                        n.tx_valid = 1'b1;
                        n.tx_char = hex_char;
                        n.rdata = {s.rdata[DATA_W_L-5:0], 4'h0};
                        n.ridx = s.ridx - 1'b1;
                    end else begin
                        n.done = 1'b1;
                        n.state = wlf_pkg::WLF_IDLE;
                    end
                end
            end
            default: begin
                n.state = wlf_pkg::WLF_IDLE;
            end
        endcase
    end

    // Registers the whole block state; setup starts at the factory value.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.state <= wlf_pkg::WLF_IDLE;
            s.setup <= wlf_pkg::FACTORY_SETUP;
            s.baud <= wlf_pkg::FACTORY_SETUP[wlf_pkg::BAUD_LSB +: wlf_pkg::BAUD_W];
        end else begin
            s <= n;
        end
    end

    assign tx_valid = s.tx_valid;
    assign tx_char = s.tx_char;
    assign resp_done = s.done;
    assign resp_status = s.status;
    assign dout = s.dout;
    assign baud_sel = s.baud;
    assign event_count = s.evcnt;

    // Checks on the sequencer.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic term_seen; // Terminator taken in the argument state.
    assign term_seen = s.state == wlf_pkg::WLF_ARGS && rx.valid && rx.last;

    setup_protect_a:
    assert property (term_seen && s.code == wlf_pkg::WLF_SETUP_WRITE_CMD && !s.we_armed
            |=> $stable(s.setup) && resp_done && resp_status == wlf_pkg::WLF_ST_PROTECT)
        else $error("Setup write without enable was not refused.");

    setup_apply_a:
    assert property (term_seen && s.code == wlf_pkg::WLF_SETUP_WRITE_CMD && s.we_armed && !s.bad
            && s.ndig == wlf_pkg::SETUP_DIGITS |=> s.setup == $past(s.argsh[31:0]) && $stable(baud_sel))
        else $error("Setup write did not apply at once or moved the baud.");

    dout_length_a:
    assert property (term_seen && s.code == wlf_pkg::WLF_PARALLEL_OUTPUT_CMD && s.ndig != want
            |=> $stable(dout) && resp_status == wlf_pkg::WLF_ST_SYNTAX)
        else $error("Wrong-length output command changed outputs.");

    dout_load_a:
    assert property (term_seen && s.code == wlf_pkg::WLF_PARALLEL_OUTPUT_CMD && s.ndig == want && !s.bad
            |=> dout == $past(s.argsh[wlf_pkg::PHYS_LINES-1:0]))
        else $error("Output command did not load the low bits.");

    reply_count_a:
    assert property (term_seen && s.code == wlf_pkg::WLF_PARALLEL_INPUT_CMD |=> s.ridx == $past(want))
        else $error("Reply digit count differs from word length.");

    setup_read_a:
    assert property (term_seen && s.code == wlf_pkg::WLF_SETUP_READ_CMD
            |=> s.ridx == wlf_pkg::SETUP_DIGITS && s.rdata[63:32] == $past(s.setup))
        else $error("Setup read did not load the full setup.");

    readback_fill_a:
    assert property (term_seen && s.code == wlf_pkg::WLF_OUTPUT_READBACK_CMD && wlen == wlf_pkg::WLEN_MAX
            |=> s.rdata == (ones_top | DATA_W_L'($past(s.dout))))
        else $error("Readback fill above physical lines is not ones.");

    enable_once_a:
    assert property (term_seen && s.code != wlf_pkg::WLF_WRITE_ENABLE_CMD |=> !s.we_armed)
        else $error("Write enable outlived the next command.");

    word_len_a:
    assert property (wlen >= wlf_pkg::WLEN_MIN && wlen <= wlf_pkg::WLEN_MAX)
        else $error("Effective word length outside one to eight.");

    event_step_a:
    assert property (evt_stable && !s.evt_prev |=> event_count == $past(event_count) + 1'b1)
        else $error("Event counter missed a filtered edge.");

    setup_write_c: cover property (term_seen && s.code == wlf_pkg::WLF_SETUP_WRITE_CMD && s.we_armed);
    syntax_c: cover property (resp_done && resp_status == wlf_pkg::WLF_ST_SYNTAX);
    reply_end_c: cover property (s.state == wlf_pkg::WLF_RESP ##1 resp_done);

endmodule

/* wlf_filter.sv */
// Debounce filter for the event counter input.
`timescale 1ns/100ps
module wlf_filter #(
    parameter int FILT5_CYC = wlf_pkg::FILT5_CYC,
    parameter int FILT20_CYC = wlf_pkg::FILT20_CYC,
    parameter int FILT50_CYC = wlf_pkg::FILT50_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic raw,
    input wire logic [1:0] sel,
    output logic stable
);

    wlf_pkg::wlf_filt_type s; // Registered state.
    wlf_pkg::wlf_filt_type n; // Next state.
    logic [wlf_pkg::FILT_CNT_W-1:0] limit; // Cycles the input must hold.

    // Picks the hold time for the current selection.
    always_comb begin
        case (sel)
            wlf_pkg::FILT_5MS: limit = wlf_pkg::FILT_CNT_W'(FILT5_CYC);
            wlf_pkg::FILT_20MS: limit = wlf_pkg::FILT_CNT_W'(FILT20_CYC);
            wlf_pkg::FILT_50MS: limit = wlf_pkg::FILT_CNT_W'(FILT50_CYC);
            default: limit = '0;
        endcase
    end

    // The sampled level must stay different from the accepted one for the
    // whole period; any return resets the count, so bounces are dropped.
    always_comb begin
        n = s;
        n.sync1 = raw;
        n.sync2 = s.sync1;
        if (sel == wlf_pkg::FILT_NONE) begin
            // Unfiltered: tracks each sample, far above the 20 kHz bandwidth.
            n.stable = s.sync2;
            n.cnt = '0;
        end else if (s.sync2 == s.stable) begin
            n.cnt = '0;
        end else if (s.cnt + 1'b1 >= limit) begin
            n.stable = s.sync2;
            n.cnt = '0;
        end else begin
            n.cnt = s.cnt + 1'b1;
        end
    end

    // Registers the filter state.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign stable = s.stable;

endmodule

/* wlf_hex.sv */
// Hex digit codec: nibble to ASCII and ASCII to nibble.
`timescale 1ns/100ps
module wlf_hex (
    input wire logic [3:0] nibble,
    input wire logic [7:0] char_in,
    output logic [7:0] char_out,
    output logic [3:0] value,
    output logic is_hex
);

    // Both conversions are pure decode; upper and lower case letters are accepted.
    always_comb begin
        char_out = (nibble < 4'hA) ? (8'h30 + {4'h0, nibble}) : (8'h37 + {4'h0, nibble});
        value = 4'h0;
        is_hex = 1'b1;
        if (char_in >= 8'h30 && char_in <= 8'h39) begin
            value = 4'(char_in - 8'h30);
        end else if (char_in >= 8'h41 && char_in <= 8'h46) begin
            value = 4'(char_in - 8'h37);
        end else if (char_in >= 8'h61 && char_in <= 8'h66) begin
            value = 4'(char_in - 8'h57);
        end else begin
            is_hex = 1'b0;
        end
    end

endmodule

/* wlf_host_model.sv */
// Host side model: takes reply digits and gathers them into one value.
`timescale 1ns/100ps
module wlf_host_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic clr,
    input wire logic tx_valid,
    input wire logic [7:0] tx_char,
    output logic tx_ready,
    output logic [7:0] n_ff,
    output logic [63:0] v_ff
);
    // Ready toggles in slow mode, so every digit after the first has to wait out a stall.
    logic gate_ff;
    assign tx_ready = slow ? gate_ff : 1'b1;
    // Each accepted digit shifts in one nibble; clr empties the collector.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_ff <= 1'b0;
            n_ff <= 8'h00;
            v_ff <= 64'h0;
        end else begin
            gate_ff <= ~gate_ff;
            if (clr) begin
                n_ff <= 8'h00;
                v_ff <= 64'h0;
            end else if (tx_valid && tx_ready) begin
                n_ff <= n_ff + 8'h01;
                v_ff <= {v_ff[59:0], (tx_char >= 8'h41) ? 4'(tx_char - 8'h37) : 4'(tx_char - 8'h30)};
            end
        end
    end
endmodule

/* wlf_pkg.sv */
// Shared constants, command codes, state encoding and state records of the setup byte 4 command block.
package wlf_pkg;

    // System clock rate in hertz.
    localparam int CLK_HZ = 20_000_000;
    // Physical I/O line count of the module.
    localparam int PHYS_LINES = 15;
    // Widest parallel value: eight words of eight bits.
    localparam int DATA_W = 64;
    // Bits in one data word.
    localparam int WORD_BITS = 8;
    // Hex digits carried by one data word.
    localparam logic [4:0] DIGITS_PER_WORD = 5'h02;
    // Hex digits in a full setup value.
    localparam logic [4:0] SETUP_DIGITS = 5'h08;
    // Hex digits in a single-line index argument.
    localparam logic [4:0] INDEX_DIGITS = 5'h02;
    // Largest digit count tracked; longer arguments saturate here.
    localparam logic [4:0] MAX_DIGITS = 5'h11;

    // Factory setup value: address one, 300 baud, no parity, two words.
    localparam logic [31:0] FACTORY_SETUP = 32'h31070102;
    // Field positions inside the 32-bit setup value.
    localparam int WLEN_LSB = 0;
    localparam int WLEN_W = 4;
    localparam int FILT_LSB = 4;
    localparam int FILT_W = 2;
    localparam int BAUD_LSB = 16;
    localparam int BAUD_W = 4;
    // Word length limits.
    localparam logic [3:0] WLEN_MIN = 4'h1;
    localparam logic [3:0] WLEN_MAX = 4'h8;

    // Filter selections.
    localparam logic [1:0] FILT_NONE = 2'h0;
    localparam logic [1:0] FILT_5MS = 2'h1;
    localparam logic [1:0] FILT_20MS = 2'h2;
    localparam logic [1:0] FILT_50MS = 2'h3;
    // Filter periods in milliseconds and their cycle counts.
    localparam int FILT5_MS = 5;
    localparam int FILT20_MS = 20;
    localparam int FILT50_MS = 50;
    localparam int FILT5_CYC = FILT5_MS * (CLK_HZ / 1000);
    localparam int FILT20_CYC = FILT20_MS * (CLK_HZ / 1000);
    localparam int FILT50_CYC = FILT50_MS * (CLK_HZ / 1000);
    // Width of the filter stability counter.
    localparam int FILT_CNT_W = 21;
    // Width of the event counter.
    localparam int EVT_W = 16;

    // Command codes presented by the character front end.
    typedef enum logic [3:0] {
        WLF_WRITE_ENABLE_CMD = 4'h0,
        WLF_SETUP_WRITE_CMD = 4'h1,
        WLF_SETUP_READ_CMD = 4'h2,
        WLF_PARALLEL_OUTPUT_CMD = 4'h3,
        WLF_PARALLEL_INPUT_CMD = 4'h4,
        WLF_OUTPUT_READBACK_CMD = 4'h5,
        WLF_INPUT_VALUE_READ_CMD = 4'h6,
        WLF_SET_BIT_CMD = 4'h7,
        WLF_CLEAR_BIT_CMD = 4'h8,
        WLF_REMOTE_RESET_CMD = 4'h9
    } wlf_cmd_type;

    // Completion status of a command.
    typedef enum logic [1:0] {
        WLF_ST_OK = 2'h0,
        WLF_ST_SYNTAX = 2'h1,
        WLF_ST_PROTECT = 2'h2
    } wlf_status_type;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        WLF_IDLE = 3'b001,
        WLF_ARGS = 3'b010,
        WLF_RESP = 3'b100
    } wlf_state_type;

    // Character arriving from the serial front end.
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] char;
    } wlf_rx_type;

    // Complete state of the command block.
    typedef struct packed {
        wlf_state_type state;
        wlf_cmd_type code;
        wlf_status_type status;
        logic [31:0] setup;
        logic [BAUD_W-1:0] baud;
        logic we_armed;
        logic [PHYS_LINES-1:0] dout;
        logic [EVT_W-1:0] evcnt;
        logic evt_prev;
        logic bad;
        logic [4:0] ndig;
        logic [DATA_W-1:0] argsh;
        logic [DATA_W-1:0] rdata;
        logic [4:0] ridx;
        logic tx_valid;
        logic [7:0] tx_char;
        logic done;
    } wlf_core_type;

    // Complete state of the event filter.
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic stable;
        logic [FILT_CNT_W-1:0] cnt;
    } wlf_filt_type;

endpackage
